// ---- rtl/twb_pkg.sv ----
package twb_pkg;

  // Byte locations of the 16-bit registers seen from the 8-bit CPU port
  localparam logic [1:0] TWB_LOC_COUNT_LO = 2'h0; // count_lower_byte_location
  localparam logic [1:0] TWB_LOC_COUNT_HI = 2'h1; // count_upper_byte_location
  localparam logic [1:0] TWB_LOC_CAPT_LO = 2'h2;
  localparam logic [1:0] TWB_LOC_CAPT_HI = 2'h3;

  // Reset values
  localparam logic [7:0] TWB_HOLD_RST = 8'h00;
  localparam logic [15:0] TWB_WORD_RST = 16'h0000;

  // CPU byte access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } twb_cpu_req_t;

  // Timer core events on the counter word
  typedef struct packed {
    logic clear;
    logic count;
  } twb_cnt_ev_t;

  // Access kind for one word register
  typedef enum logic [1:0] {
    TWB_ACC_NONE = 2'b00,
    TWB_ACC_RD_LO = 2'b01,
    TWB_ACC_WR_LO = 2'b10
  } twb_acc_t;

endpackage

// ---- rtl/twb_word_reg.sv ----
// One 16-bit timer word with a low-byte-triggered load from the CPU side
module twb_word_reg
  import twb_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // CPU side
  input wire logic cpu_load_i,
  input wire logic [15:0] cpu_word_i,
  // Hardware side
  input wire logic hw_load_i,
  input wire logic [15:0] hw_word_i,
  input wire logic hw_clear_i,
  input wire logic hw_count_i,
  // Current value
  output logic [15:0] word_o
);

  logic [15:0] word_r;

  // CPU load first, then hardware load, clear, count
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_r <= TWB_WORD_RST;
    end else if (cpu_load_i) begin
      word_r <= cpu_word_i;
    end else if (hw_load_i) begin
      word_r <= hw_word_i;
    end else if (hw_clear_i) begin
      word_r <= TWB_WORD_RST;
    end else if (hw_count_i) begin
      word_r <= word_r + 16'h0001;
    end
  end

  assign word_o = word_r;

  // A CPU load beats any clear or count in the same cycle
  cpu_prio_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cpu_load_i |=> word_r == $past(cpu_word_i))
    else $error("cpu word load lost to a timer event");

endmodule

// ---- rtl/twb_access.sv ----
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - One 8-bit high-byte holder is shared by both 16-bit registers.
// - Only a low-byte access moves a full word; a high-byte access touches the holder only.
// - A low-byte write loads holder and written byte into the word in one cycle.
// - A low-byte read returns the low byte and copies the upper half into the holder.
// - The holder keeps its value across low-byte writes so it can be reused.
// - High-byte locations read and write the holder, never the word's upper half.
// - A CPU counter write wins over a clear or count in the same cycle.
// - Capture value writes are taken only when the mode uses it as top value.
////////////////////////////////////////////////////////////////////////////////
module twb_access
  import twb_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // CPU byte port
  input wire twb_pkg::twb_cpu_req_t cpu_req_i,
  output logic [7:0] cpu_rdata_o,
  // Timer core
  input wire twb_pkg::twb_cnt_ev_t cnt_ev_i,
  input wire logic capt_top_mode_i,
  input wire logic capt_load_i,
  // Word views
  output logic [15:0] timer_count_value_o,
  output logic [15:0] capture_value_o
);

  import twb_pkg::*;

  logic [7:0] hold_r;
  logic [7:0] rdata_r;
  logic [7:0] hold_nxt;
  logic [7:0] rdata_nxt;
  logic [15:0] cnt_w;
  logic [15:0] cap_w;
  logic [15:0] cnt_q_r;
  logic [15:0] cap_q_r;
  twb_acc_t cnt_acc;
  twb_acc_t cap_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Decode: only low-byte locations start a word access
  always_comb begin
    cnt_acc = TWB_ACC_NONE;
    cap_acc = TWB_ACC_NONE;
    if (cpu_req_i.addr == TWB_LOC_COUNT_LO) begin
      if (cpu_req_i.wr) begin
        cnt_acc = TWB_ACC_WR_LO;
      end else if (cpu_req_i.rd) begin
        cnt_acc = TWB_ACC_RD_LO;
      end
    end
    if (cpu_req_i.addr == TWB_LOC_CAPT_LO) begin
      // Writes ignored silently outside top-value modes
      if (cpu_req_i.wr && capt_top_mode_i) begin
        cap_acc = TWB_ACC_WR_LO;
      end else if (cpu_req_i.rd && !cpu_req_i.wr) begin
        cap_acc = TWB_ACC_RD_LO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word registers, each loaded from holder plus written byte
  twb_word_reg u_count (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cpu_load_i(cnt_acc == TWB_ACC_WR_LO),
    .cpu_word_i({hold_r, cpu_req_i.wdata}),
    .hw_load_i(1'b0),
    .hw_word_i(TWB_WORD_RST),
    .hw_clear_i(cnt_ev_i.clear),
    .hw_count_i(cnt_ev_i.count),
    .word_o(cnt_w)
  );

  twb_word_reg u_capture (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cpu_load_i(cap_acc == TWB_ACC_WR_LO),
    .cpu_word_i({hold_r, cpu_req_i.wdata}),
    .hw_load_i(capt_load_i),
    .hw_word_i(cnt_w),
    .hw_clear_i(1'b0),
    .hw_count_i(1'b0),
    .word_o(cap_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared holder: one byte for all words, kept across low-byte writes
  always_comb begin
    hold_nxt = hold_r;
    if (cnt_acc == TWB_ACC_RD_LO) begin
      hold_nxt = cnt_w[15:8];
    end else if (cap_acc == TWB_ACC_RD_LO) begin
      hold_nxt = cap_w[15:8];
    end else if (cpu_req_i.wr && cpu_req_i.addr[0]) begin
      hold_nxt = cpu_req_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= TWB_HOLD_RST;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the request
  always_comb begin
    rdata_nxt = rdata_r;
    if (cpu_req_i.rd && !cpu_req_i.wr) begin
      unique case (cpu_req_i.addr)
        TWB_LOC_COUNT_LO: rdata_nxt = cnt_w[7:0];
        TWB_LOC_CAPT_LO: rdata_nxt = cap_w[7:0];
        TWB_LOC_COUNT_HI, TWB_LOC_CAPT_HI: rdata_nxt = hold_r;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= TWB_HOLD_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered copies so outputs come straight from flip-flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q_r <= TWB_WORD_RST;
      cap_q_r <= TWB_WORD_RST;
    end else begin
      cnt_q_r <= cnt_w;
      cap_q_r <= cap_w;
    end
  end

  assign cpu_rdata_o = rdata_r;
  assign timer_count_value_o = cnt_q_r;
  assign capture_value_o = cap_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  hold_reset_a: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> hold_r == TWB_HOLD_RST)
    else $error("holder not zero after reset");

  low_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_LO && !cnt_ev_i.clear)
      |=> cnt_w == {$past(hold_r), $past(cpu_req_i.wdata)})
    else $error("counter word not loaded from holder and low byte");

  low_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.rd && !cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_LO)
      |=> hold_r == $past(cnt_w[15:8]) && cpu_rdata_o == $past(cnt_w[7:0]))
    else $error("low read did not latch upper half");

  hold_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && !cpu_req_i.addr[0]) |=> $stable(hold_r))
    else $error("holder changed on low-byte write");

  high_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_HI && !cnt_ev_i.clear
      && !cnt_ev_i.count) |=> $stable(cnt_w) && hold_r == $past(cpu_req_i.wdata))
    else $error("high-byte write reached the word");

  high_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.rd && !cpu_req_i.wr && cpu_req_i.addr[0])
      |=> cpu_rdata_o == $past(hold_r))
    else $error("high-byte read did not return holder");

  capt_guard_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_LO && !capt_top_mode_i
      && !capt_load_i) |=> $stable(cap_w))
    else $error("capture value written outside top mode");

  shared_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_HI)
      ##1 (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_LO && capt_top_mode_i)
      |=> cap_w[15:8] == $past(cpu_req_i.wdata, 2))
    else $error("capture upper half not taken from shared holder");

  // The holder is shared both ways: a capture high byte feeds the counter too
  shared_back_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_HI)
      ##1 (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_LO)
      |=> cnt_w[15:8] == $past(cpu_req_i.wdata, 2))
    else $error("counter upper half not taken from shared holder");

  capt_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_LO && capt_top_mode_i)
      |=> cap_w == {$past(hold_r), $past(cpu_req_i.wdata)})
    else $error("capture word not loaded from holder and low byte");

  capt_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.rd && !cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_LO)
      |=> hold_r == $past(cap_w[15:8]) && cpu_rdata_o == $past(cap_w[7:0]))
    else $error("capture low read did not latch upper half");

  capt_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_CAPT_HI && !capt_load_i)
      |=> $stable(cap_w) && hold_r == $past(cpu_req_i.wdata))
    else $error("high-byte write reached the capture word");

  // Only a low read or a high write may touch the holder
  high_rd_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.rd && !cpu_req_i.wr && cpu_req_i.addr[0]) |=> $stable(hold_r))
    else $error("high-byte read changed the holder");

  cnt_prio_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cpu_req_i.wr && cpu_req_i.addr == TWB_LOC_COUNT_LO && cnt_ev_i.clear)
      |=> cnt_w == {$past(hold_r), $past(cpu_req_i.wdata)})
    else $error("counter write lost to a clear");

endmodule

// ---- verif/twb_cpu_model.sv ----
// Behavioural 8-bit CPU core on the byte port; it takes no interrupts
module twb_cpu_model (
  // Clock
  input wire logic clock_i,
  // Byte port
  output twb_pkg::twb_cpu_req_t cpu_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import twb_pkg::*;

  initial cpu_req_o = '0;

  // One access per cycle; callers chain these back to back
  task automatic acc(input logic rd, input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(negedge clock_i);
    cpu_req_o = '{rd: rd, wr: wr, addr: a, wdata: d};
  endtask

  // Strobes low; address and data wander so stale values never look valid
  task automatic idle();
    acc(1'b0, 1'b0, 2'($urandom), 8'($urandom));
  endtask

  // High byte first, nothing between the two bytes
  task automatic wr16(input logic [1:0] lo, input logic [15:0] v);
    acc(1'b0, 1'b1, lo + 2'h1, v[15:8]);
    acc(1'b0, 1'b1, lo, v[7:0]);
    idle();
  endtask

  // Low byte first so the holder carries the matching upper half
  task automatic rd16(input logic [1:0] lo);
    acc(1'b1, 1'b0, lo, 8'h00);
    acc(1'b1, 1'b0, lo + 2'h1, 8'h00);
    idle();
  endtask
endmodule

// ---- verif/twb_access_tb_top.sv ----
module twb_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import twb_pkg::*;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  twb_cpu_req_t cpu_req;
  twb_cnt_ev_t cnt_ev = '0;
  logic capt_top = 1'b0;
  logic capt_load = 1'b0;
  logic ev_on = 1'b0;
  logic [7:0] rdata, m_hold, m_rdata;
  logic [15:0] cnt_o, cap_o, m_cnt, m_cap, m_cnt_d, m_cap_d;
  int errors = 0;
  int n_checks = 0;

  twb_access dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req),
    .cpu_rdata_o(rdata), .cnt_ev_i(cnt_ev), .capt_top_mode_i(capt_top),
    .capt_load_i(capt_load), .timer_count_value_o(cnt_o), .capture_value_o(cap_o));
  twb_cpu_model cpu (.clock_i(clock_i), .cpu_req_o(cpu_req));

  initial forever #5 clock_i = ~clock_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model; word outputs lag the internal word by one cycle
  always @(posedge clock_i or negedge rst_n_i) begin
    logic cw, kw;
    if (!rst_n_i) begin
      {m_hold, m_rdata, m_cnt, m_cap, m_cnt_d, m_cap_d} = '0;
    end else begin
      m_cnt_d = m_cnt;
      m_cap_d = m_cap;
      cw = cpu_req.wr && cpu_req.addr == TWB_LOC_COUNT_LO;
      kw = cpu_req.wr && cpu_req.addr == TWB_LOC_CAPT_LO && capt_top;
      if (cpu_req.rd && !cpu_req.wr) begin
        case (cpu_req.addr)
          TWB_LOC_COUNT_LO: {m_hold, m_rdata} = m_cnt;
          TWB_LOC_CAPT_LO: {m_hold, m_rdata} = m_cap;
          default: m_rdata = m_hold;
        endcase
      end
      if (kw) m_cap = {m_hold, cpu_req.wdata};
      else if (capt_load) m_cap = m_cnt;
      if (cw) m_cnt = {m_hold, cpu_req.wdata};
      else if (cnt_ev.clear) m_cnt = '0;
      else if (cnt_ev.count) m_cnt = m_cnt + 16'h1;
      if (cpu_req.wr && cpu_req.addr[0]) m_hold = cpu_req.wdata;
    end
  end

  // Compare every cycle, away from the sampling edge
  always @(negedge clock_i) begin
    if (rst_n_i) begin
      `CHK("rdata", m_rdata, rdata)
      `CHK("count", m_cnt_d, cnt_o)
      `CHK("capture", m_cap_d, cap_o)
    end
  end

  // Random core events collide with CPU writes on purpose
  always @(negedge clock_i) begin
    cnt_ev <= '{clear: ev_on && $urandom % 8 == 0, count: ev_on && $urandom % 2 == 1};
    capt_load <= ev_on && $urandom % 6 == 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    rst_n_i = 1'b0;
    // Six full rising edges in reset, then release away from the edge
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog far beyond the roughly 460 cycles of traffic
  initial begin
    #50000;
    errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hf24f));
    do_reset();
    cpu.acc(1'b1, 1'b0, TWB_LOC_COUNT_HI, 8'h00);
    cpu.idle();
    $display("test reset_holder done");
    ev_on <= 1'b1;
    repeat (20) cpu.wr16(TWB_LOC_COUNT_LO, 16'($urandom));
    repeat (20) cpu.rd16(TWB_LOC_COUNT_LO);
    $display("test count_words done");
    // One upper byte feeds both words, capture word straight after the high byte
    capt_top <= 1'b1;
    cpu.acc(1'b0, 1'b1, TWB_LOC_COUNT_HI, 8'($urandom));
    cpu.acc(1'b0, 1'b1, TWB_LOC_CAPT_LO, 8'($urandom));
    cpu.acc(1'b0, 1'b1, TWB_LOC_COUNT_LO, 8'($urandom));
    cpu.rd16(TWB_LOC_CAPT_LO);
    $display("test shared_holder done");
    capt_top <= 1'b0;
    repeat (5) cpu.wr16(TWB_LOC_CAPT_LO, 16'($urandom));
    cpu.acc(1'b0, 1'b1, TWB_LOC_CAPT_HI, 8'($urandom));
    cpu.acc(1'b0, 1'b1, TWB_LOC_COUNT_LO, 8'($urandom));
    cpu.acc(1'b1, 1'b0, TWB_LOC_COUNT_HI, 8'h00);
    cpu.idle();
    $display("test refused_and_high done");
    repeat (300) begin
      capt_top <= 1'($urandom);
      cpu.acc(1'($urandom), 1'($urandom), 2'($urandom), 8'($urandom));
    end
    cpu.idle();
    $display("test random_mix done");
    do_reset();
    cpu.rd16(TWB_LOC_COUNT_LO);
    $display("test mid_reset done");
    wrap_up();
  end
endmodule
